/* src/jtl_pkg.sv */
// Shared constants, types and link mode decode for the link transmit front end.
// Assumes one device clock; all users import this package.
package jtl_pkg;

  localparam int SMP_W      = 16;
  localparam int ACC_W      = 22;
  localparam int FIFO_W     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int LANES_MAX  = 16;
  localparam int MODE_W     = 5;
  localparam int MF_CYC     = 32;
  localparam int LMFC_W     = 5;
  localparam int ILAS_MF    = 4;
  localparam int BLK_OCT    = 8;
  localparam int MODE_IS66  = 3;

  localparam logic [7:0] K28_5    = 8'hBC;
  localparam logic [7:0] K28_0    = 8'h1C;
  localparam logic [7:0] K28_3    = 8'h7C;
  localparam logic [7:0] OCT_IDLE = 8'h00;
  localparam logic [1:0] SH_DATA  = 2'h1;

  typedef enum logic [2:0] {DEC_BYPASS, DEC_4, DEC_8, DEC_16, DEC_32} jtl_dec_t;
  typedef enum logic [1:0] {ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} jtl_state_t;

  // Decimation follows the link mode setting, low three bits
  function automatic jtl_dec_t jtl_mode_dec(input logic [MODE_W-1:0] m);
    unique case (m[2:0])
      3'h1:    jtl_mode_dec = DEC_4;
      3'h2:    jtl_mode_dec = DEC_8;
      3'h3:    jtl_mode_dec = DEC_16;
      3'h4:    jtl_mode_dec = DEC_32;
      default: jtl_mode_dec = DEC_BYPASS;
    endcase
  endfunction

  // Fewer lanes as the sample rate drops
  function automatic logic [LANES_MAX-1:0] jtl_mode_lanes(input logic [MODE_W-1:0] m);
    unique case (jtl_mode_dec(m))
      DEC_BYPASS: jtl_mode_lanes = 16'hFFFF;
      DEC_4:      jtl_mode_lanes = 16'h00FF;
      DEC_8:      jtl_mode_lanes = 16'h000F;
      DEC_16:     jtl_mode_lanes = 16'h0003;
      DEC_32:     jtl_mode_lanes = 16'h0001;
    endcase
  endfunction

endpackage

/* src/jtl_fifo.sv */
// Sample FIFO between the decimator and the octet framer.
// Assumes both sides on clk; depth is a power of two.
`timescale 1ns/1ps
module jtl_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0]   count_q;
  wire           push;
  wire           pop;

  // Full and empty come straight from the count
  assign inReady  = count_q != (AW+1)'(DEPTH);
  assign outValid = count_q != '0;
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Storage has no reset, it is never read while empty
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* src/jtl_decim.sv */
// Accumulate-and-dump decimator with optional x2 gain boost.
// Assumes I/Q arrive already mixed; the sink may stall the output word.
`timescale 1ns/1ps
module jtl_decim (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire jtl_pkg::jtl_dec_t             decSel,
  input  wire logic                          boost,
  input  wire logic                          inValid,
  input  wire logic signed [jtl_pkg::SMP_W-1:0] inI,
  input  wire logic signed [jtl_pkg::SMP_W-1:0] inQ,
  output logic                               outValid,
  input  wire logic                          outReady,
  output logic [jtl_pkg::FIFO_W-1:0]         outData,
  output logic                               dropped
);
  import jtl_pkg::*;

  // Log2 of the decimation ratio
  function automatic logic [2:0] decShift(input jtl_dec_t d);
    unique case (d)
      DEC_BYPASS: decShift = 3'h0;
      DEC_4:      decShift = 3'h2;
      DEC_8:      decShift = 3'h3;
      DEC_16:     decShift = 3'h4;
      DEC_32:     decShift = 3'h5;
    endcase
  endfunction

  // Boost doubles the sum (6.02 dB); otherwise the chain is unity
  function automatic logic [SMP_W-1:0] scale(input logic signed [ACC_W-1:0] s,
                                             input logic b, input logic [2:0] n);
    logic signed [ACC_W:0] v;
    v = b ? {s, 1'b0} : {s[ACC_W-1], s};
    v = v >>> n;
    if (v[ACC_W:SMP_W-1] != {(ACC_W-SMP_W+2){v[ACC_W]}}) begin
      scale = v[ACC_W] ? {1'b1, {(SMP_W-1){1'b0}}} : {1'b0, {(SMP_W-1){1'b1}}};
    end else begin
      scale = v[SMP_W-1:0];
    end
  endfunction

  logic [4:0]              cnt_q;
  logic signed [ACC_W-1:0] accI_q;
  logic signed [ACC_W-1:0] accQ_q;
  logic                    outValid_q;
  logic [FIFO_W-1:0]       outData_q;
  logic                    dropped_q;
  wire  [2:0]              sh      = decShift(decSel);
  wire  [4:0]              lastIdx = 5'((32'd1 << sh) - 32'd1);
  wire                     dump    = inValid && cnt_q == lastIdx;
  wire                     room    = !outValid_q || outReady;
  wire  signed [ACC_W-1:0] sumI    = accI_q + ACC_W'(inI);
  wire  signed [ACC_W-1:0] sumQ    = accQ_q + ACC_W'(inQ);
  wire                     isReal  = decSel == DEC_BYPASS;
  // Bypass carries real samples, the Q half is zero
  wire  [SMP_W-1:0]        resI    = scale(sumI, boost, sh);
  wire  [SMP_W-1:0]        resQ    = isReal ? '0 : scale(sumQ, boost, sh);

  assign outValid = outValid_q;
  assign outData  = outData_q;
  assign dropped  = dropped_q;

  // A full FIFO stalls the word; a finished sum with no room is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q      <= '0;
      accI_q     <= '0;
      accQ_q     <= '0;
      outValid_q <= 1'b0;
      outData_q  <= '0;
      dropped_q  <= 1'b0;
    end else begin
      dropped_q <= dump && !room;
      if (outReady) begin
        outValid_q <= 1'b0;
      end
      if (dump) begin
        cnt_q  <= '0;
        accI_q <= '0;
        accQ_q <= '0;
        if (room) begin
          outValid_q <= 1'b1;
          outData_q  <= {resI, resQ};
        end
      end else if (inValid) begin
        cnt_q  <= cnt_q + 5'h1;
        accI_q <= sumI;
        accQ_q <= sumQ;
      end
    end
  end

  property p_unity;
    @(posedge clk) disable iff (!rst_b)
    inValid && isReal && !boost && room |=> outValid_q && outData_q[FIFO_W-1 -: SMP_W] == $past(inI);
  endproperty
  a_unity: assert property (p_unity) else $error("bypass without boost is not unity");

  property p_boost;
    @(posedge clk) disable iff (!rst_b)
    dump && room && boost && decSel == DEC_4 && !sumI[ACC_W-1] && sumI < 22'sh1_0000
      |=> outData_q[FIFO_W-1 -: SMP_W] == SMP_W'($past(sumI) >>> 1);
  endproperty
  a_boost: assert property (p_boost) else $error("boost does not double the sample");
endmodule

/* src/jtl_link_tx.sv */
// Link transmit front end: decimation, sample FIFO and octet framing for
// 8B/10B and 64B/66B lanes. Assumes configuration pins and SYNC/SYSREF are
// asynchronous; the serializer and line coders sit downstream of laneOctet.
`timescale 1ns/1ps

module jtl_link_tx (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic [jtl_pkg::MODE_W-1:0]    linkModeSetting,
  input  wire logic                          gainBoost,
  input  wire logic                          fecEnable,
  input  wire logic                          syncIsOsc,
  input  wire logic                          syncIn_b,
  input  wire logic                          sysrefIn,
  input  wire logic                          smpValid,
  input  wire logic signed [jtl_pkg::SMP_W-1:0] smpI,
  input  wire logic signed [jtl_pkg::SMP_W-1:0] smpQ,
  output logic [7:0]                         laneOctet,
  output logic                               laneIsK,
  output logic [jtl_pkg::LANES_MAX-1:0]      laneEnable,
  output logic [1:0]                         syncHeader,
  output logic                               blockStart,
  output logic                               encode66,
  output logic                               fecActive,
  output logic                               oscSyncPulse,
  output logic                               multiframeStart,
  output logic                               linkUp,
  output logic                               sampleDropped
);
  import jtl_pkg::*;

  localparam int SYN_W = MODE_W + 5;

  logic [SYN_W-1:0]     meta_q;
  logic [SYN_W-1:0]     sync_q;
  logic [MODE_W-1:0]    modePrev_q;
  logic                 sysrefPrev_q;
  logic                 syncPrev_q;
  logic [LMFC_W-1:0]    lmfc_q;
  logic [1:0]           mf_q;
  logic [1:0]           mf_d;
  jtl_state_t           state_q;
  jtl_state_t           state_d;
  logic [1:0]           byteIdx_q;
  logic [2:0]           blkPos_q;
  logic [7:0]           octD;
  logic                 kD;
  logic [7:0]           laneOctet_q;
  logic                 laneIsK_q;
  logic [LANES_MAX-1:0] laneEnable_q;
  logic [1:0]           syncHeader_q;
  logic                 blockStart_q;
  logic                 encode66_q;
  logic                 fecActive_q;
  logic                 oscSyncPulse_q;
  logic                 multiframeStart_q;
  logic                 linkUp_q;
  logic                 sampleDropped_q;

  wire                  decValid;
  wire                  decReady;
  wire [FIFO_W-1:0]     decData;
  wire                  decDrop;
  wire                  fifoValid;
  wire [FIFO_W-1:0]     fifoData;

  // Synchronised pin view; only sync_q is read by logic
  wire [MODE_W-1:0] modeS    = sync_q[SYN_W-1 -: MODE_W];
  wire              boostS   = sync_q[4];
  wire              fecS     = sync_q[3];
  wire              oscS     = sync_q[2];
  wire              syncHi   = sync_q[1];
  wire              sysrefS  = sync_q[0];

  // Mode decode; only two line codings exist in the mode table
  wire jtl_dec_t    decSel   = jtl_mode_dec(modeS);
  wire              is66     = modeS[MODE_IS66];
  wire              isReal   = decSel == DEC_BYPASS;
  wire              modeChg  = modeS != modePrev_q;
  wire              sysrefRise = sysrefS && !sysrefPrev_q;
  wire              syncFell = syncPrev_q && !syncHi;
  wire              lmfcEdge = lmfc_q == LMFC_W'(MF_CYC - 1);

  // Byte walk through one FIFO word: two bytes real, four complex
  wire [1:0]        lastByte = isReal ? 2'h1 : 2'h3;
  wire [FIFO_W-1:0] shData   = fifoData << {byteIdx_q, 3'h0};
  wire [7:0]        curByte  = shData[FIFO_W-1 -: 8];
  wire              inData   = state_q == ST_DATA;
  wire              pop      = inData && fifoValid && byteIdx_q == lastByte;

  jtl_decim u_decim (
    .clk      (clk),
    .rst_b    (rst_b),
    .decSel   (decSel),
    .boost    (boostS),
    .inValid  (smpValid),
    .inI      (smpI),
    .inQ      (smpQ),
    .outValid (decValid),
    .outReady (decReady),
    .outData  (decData),
    .dropped  (decDrop)
  );

  jtl_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (decValid),
    .inReady  (decReady),
    .inData   (decData),
    .outValid (fifoValid),
    .outReady (pop),
    .outData  (fifoData)
  );

  // Two-stage synchroniser, SYNC level sampled regardless of legacy timing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {linkModeSetting, gainBoost, fecEnable, syncIsOsc, syncIn_b, sysrefIn};
      sync_q <= meta_q;
    end
  end

  // Edge history for SYSREF, SYNC and mode changes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modePrev_q   <= '0;
      sysrefPrev_q <= 1'b0;
      syncPrev_q   <= 1'b0;
    end else begin
      modePrev_q   <= modeS;
      sysrefPrev_q <= sysrefS;
      syncPrev_q   <= syncHi;
    end
  end

  // One counter serves as LMFC or LEMC; subclass 1 timing via SYSREF
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lmfc_q <= '0;
    end else if (sysrefRise) begin
      lmfc_q <= '0;
    end else begin
      lmfc_q <= lmfc_q + LMFC_W'(1);
    end
  end

  // Link sequencing; a mode change restarts from comma transmission
  always_comb begin
    state_d = state_q;
    mf_d    = mf_q;
    if (modeChg) begin
      state_d = ST_CGS;
    end else if (is66) begin
      state_d = ST_DATA;
    end else if (!syncHi) begin
      state_d = ST_CGS;
    end else begin
      unique case (state_q)
        ST_CGS: state_d = ST_WAIT;
        ST_WAIT: if (lmfcEdge) begin
          state_d = ST_ILAS;
          mf_d    = '0;
        end
        ST_ILAS: if (lmfcEdge) begin
          mf_d = mf_q + 2'h1;
          if (mf_q == 2'(ILAS_MF - 1)) begin
            state_d = ST_DATA;
          end
        end
        ST_DATA: state_d = ST_DATA;
      endcase
    end
  end

  // Octet choice; ILAS multiframes open with /R/ and close with /A/
  always_comb begin
    octD = OCT_IDLE;
    kD   = 1'b0;
    unique case (state_q)
      ST_CGS, ST_WAIT: begin
        octD = K28_5;
        kD   = 1'b1;
      end
      ST_ILAS: begin
        if (lmfc_q == '0) begin
          octD = K28_0;
          kD   = 1'b1;
        end else if (lmfcEdge) begin
          octD = K28_3;
          kD   = 1'b1;
        end else begin
          octD = 8'(lmfc_q);
        end
      end
      ST_DATA: octD = fifoValid ? curByte : OCT_IDLE;
    endcase
  end

  // State and byte position
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= ST_CGS;
      mf_q      <= '0;
      byteIdx_q <= '0;
      blkPos_q  <= '0;
    end else begin
      state_q   <= state_d;
      mf_q      <= mf_d;
      byteIdx_q <= (pop || !inData) ? 2'h0 : byteIdx_q + 2'(fifoValid);
      blkPos_q  <= blkPos_q + 3'h1; // blocks of BLK_OCT octets
    end
  end

  // All enabled lanes get the same octet in the same cycle, so they align
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      laneOctet_q  <= K28_5;
      laneIsK_q    <= 1'b1;
      laneEnable_q <= '0;
    end else begin
      laneOctet_q  <= octD;
      laneIsK_q    <= kD && !is66;
      laneEnable_q <= jtl_mode_lanes(modeS);
    end
  end

  // 64B/66B block framing, FEC and oscillator sync on the SYNC pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncHeader_q      <= '0;
      blockStart_q      <= 1'b0;
      encode66_q        <= 1'b0;
      fecActive_q       <= 1'b0;
      oscSyncPulse_q    <= 1'b0;
      multiframeStart_q <= 1'b0;
      linkUp_q          <= 1'b0;
      sampleDropped_q   <= 1'b0;
    end else begin
      blockStart_q      <= is66 && blkPos_q == '0;
      syncHeader_q      <= (is66 && blkPos_q == '0) ? SH_DATA : 2'h0;
      encode66_q        <= is66;
      fecActive_q       <= fecS && is66;
      oscSyncPulse_q    <= oscS && is66 && syncFell;
      multiframeStart_q <= lmfc_q == '0;
      linkUp_q          <= inData;
      sampleDropped_q   <= decDrop;
    end
  end

  assign laneOctet       = laneOctet_q;
  assign laneIsK         = laneIsK_q;
  assign laneEnable      = laneEnable_q;
  assign syncHeader      = syncHeader_q;
  assign blockStart      = blockStart_q;
  assign encode66        = encode66_q;
  assign fecActive       = fecActive_q;
  assign oscSyncPulse    = oscSyncPulse_q;
  assign multiframeStart = multiframeStart_q;
  assign linkUp          = linkUp_q;
  assign sampleDropped   = sampleDropped_q;

  property p_cgs_comma;
    @(posedge clk) disable iff (!rst_b)
    state_q == ST_CGS && !is66 |=> laneOctet_q == K28_5 && laneIsK_q;
  endproperty
  a_cgs_comma: assert property (p_cgs_comma) else $error("no comma during CGS");

  property p_wait_hold;
    @(posedge clk) disable iff (!rst_b)
    state_q == ST_WAIT && !lmfcEdge && syncHi && !is66 && !modeChg |=> state_q == ST_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("ILAS began off the edge");

  property p_ilas_go;
    @(posedge clk) disable iff (!rst_b)
    state_q == ST_WAIT && lmfcEdge && syncHi && !is66 && !modeChg && !sysrefRise
      |=> state_q == ST_ILAS && lmfc_q == '0 ##1 laneOctet_q == K28_0;
  endproperty
  a_ilas_go: assert property (p_ilas_go) else $error("ILAS not started at edge");

  property p_sysref;
    @(posedge clk) disable iff (!rst_b)
    sysrefRise |=> lmfc_q == '0;
  endproperty
  a_sysref: assert property (p_sysref) else $error("SYSREF did not reset counter");

  property p_ignore_sync;
    @(posedge clk) disable iff (!rst_b)
    is66 && !modeChg && state_q == ST_DATA && $fell(syncHi) |=> (state_q == ST_DATA) [*2];
  endproperty
  a_ignore_sync: assert property (p_ignore_sync) else $error("SYNC disturbed 64B/66B");

  property p_fec;
    @(posedge clk) disable iff (!rst_b)
    !is66 |=> !fecActive_q;
  endproperty
  a_fec: assert property (p_fec) else $error("FEC active outside 64B/66B");

  property p_hdr;
    @(posedge clk) disable iff (!rst_b)
    is66 && blkPos_q == '0 |=> blockStart_q && syncHeader_q == SH_DATA;
  endproperty
  a_hdr: assert property (p_hdr) else $error("missing block sync header");

  property p_lanes;
    @(posedge clk) disable iff (!rst_b)
    decSel == DEC_BYPASS |=> $countones(laneEnable_q) == LANES_MAX;
  endproperty
  a_lanes: assert property (p_lanes) else $error("bypass not on all lanes");
endmodule

/* verif/jtl_rx_model.sv */
// Behavioural receiving logic device on the far side of the lanes.
// Assumes one shared device clock; it drives only the active-low SYNC line.
`timescale 1ns/1ps
module jtl_rx_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       wantLink,
  input  wire logic       holdOff,
  input  wire logic [7:0] laneOctet,
  input  wire logic       laneIsK,
  input  wire logic       multiframeStart,
  output logic            syncIn_b
);
  logic [2:0] commaCnt_q;
  logic       locked_q;
  logic       isComma;

  // Comma detection on the shared octet stream
  assign isComma = laneIsK && (laneOctet == 8'hBC);

  // Request with SYNC low; release on a multiframe edge after four commas (holdOff stalls us)
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncIn_b   <= 1'b1;
      commaCnt_q <= 3'h0;
      locked_q   <= 1'b0;
    end else if (!wantLink) begin
      syncIn_b   <= 1'b1;
      commaCnt_q <= 3'h0;
      locked_q   <= 1'b0;
    end else if (!locked_q) begin
      syncIn_b <= 1'b0;
      if (!isComma) begin
        commaCnt_q <= 3'h0;
      end else if (commaCnt_q != 3'h4) begin
        commaCnt_q <= commaCnt_q + 3'h1;
      end
      if (commaCnt_q == 3'h4 && !holdOff && multiframeStart) begin
        syncIn_b <= 1'b1;
        locked_q <= 1'b1;
      end
    end
  end
endmodule

/* verif/tb_jtl_link_tx.sv */
// Self-checking bench for the link transmit front end.
// Assumes the receiver model drives SYNC; all other pins are driven here.
`timescale 1ns/1ps
module tb_jtl_link_tx;
  import jtl_pkg::*;
  logic        clk = 0, rst_b = 0, gainBoost = 0, fecEnable = 1, syncIsOsc = 0, sysrefIn = 0;
  logic        smpValid = 0, wantLink = 0, holdOff = 0, syncIn_b;
  logic [4:0]  linkModeSetting = 5'h01;
  logic [15:0] smpI = 16'h0000, smpQ = 16'h0000, laneEnable;
  logic [7:0]  laneOctet;
  logic [1:0]  syncHeader;
  logic        laneIsK, blockStart, encode66, fecActive, oscSyncPulse, multiframeStart, linkUp, sampleDropped;
  int          badCount = 0, comparisons = 0, dropCnt = 0, oscCnt = 0;

  jtl_link_tx DUT (.clk(clk), .rst_b(rst_b), .linkModeSetting(linkModeSetting), .gainBoost(gainBoost),
    .fecEnable(fecEnable), .syncIsOsc(syncIsOsc), .syncIn_b(syncIn_b), .sysrefIn(sysrefIn),
    .smpValid(smpValid), .smpI(smpI), .smpQ(smpQ), .laneOctet(laneOctet), .laneIsK(laneIsK),
    .laneEnable(laneEnable), .syncHeader(syncHeader), .blockStart(blockStart), .encode66(encode66),
    .fecActive(fecActive), .oscSyncPulse(oscSyncPulse), .multiframeStart(multiframeStart),
    .linkUp(linkUp), .sampleDropped(sampleDropped));
  jtl_rx_model partner (.clk(clk), .rst_b(rst_b), .wantLink(wantLink), .holdOff(holdOff),
    .laneOctet(laneOctet), .laneIsK(laneIsK), .multiframeStart(multiframeStart), .syncIn_b(syncIn_b));

  // 25 MHz device clock
  always #20 clk = ~clk;

  // Pulse counters; outputs are registered so the edge sees settled values
  always @(posedge clk) begin
    if (sampleDropped === 1'b1) dropCnt++;
    if (oscSyncPulse === 1'b1) oscCnt++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Step to just after a clock edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for an octet; the caller judges what it finds
  task automatic wait_oct(input logic [7:0] o, input logic k, input int lim);
    int n;
    n = 0;
    while (!(laneOctet === o && laneIsK === k) && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic feed(input int n, input logic [15:0] i, input logic [15:0] q);
    @(posedge clk);
    smpValid <= 1'b1;
    smpI     <= i;
    smpQ     <= q;
    repeat (n) @(posedge clk);
    smpValid <= 1'b0;
  endtask

  // SYNC low gives commas; the buffer fills and refuses while the link is down
  task automatic t_cgs;
    @(posedge clk);
    wantLink <= 1'b1;
    holdOff  <= 1'b1;
    cyc(10);
    chk(laneOctet, 16'h00BC);
    chk(laneIsK, 16'h0001);
    chk(fecActive, 16'h0000);
    feed(80, 16'h1234, 16'h0567);
    cyc(6);
    chk(16'(dropCnt != 0), 16'h0001);
    chk(linkUp, 16'h0000);
    $display("test cgs done");
  endtask

  // Alignment sequence framing, then the buffer drains to idle
  task automatic t_ilas;
    @(posedge clk);
    holdOff <= 1'b0;
    wait_oct(8'h1C, 1'b1, 200);
    chk(laneOctet, 16'h001C);
    cyc(31);
    chk(laneOctet, 16'h007C);
    chk(laneIsK, 16'h0001);
    cyc(100);
    chk(linkUp, 16'h0001);
    wait_oct(8'h00, 1'b0, 300);
    chk(laneOctet, 16'h0000);
    $display("test ilas done");
  endtask

  // Decimate by four; boost doubles the word
  task automatic t_data(input logic b, input logic [15:0] ei, input logic [15:0] eq);
    @(posedge clk);
    gainBoost <= b;
    cyc(4);
    feed(4, 16'h1234, 16'h0567);
    wait_oct(ei[15:8], 1'b0, 40);
    chk(laneOctet, ei[15:8]);
    cyc(1);
    chk(laneOctet, ei[7:0]);
    cyc(1);
    chk(laneOctet, eq[15:8]);
    cyc(1);
    chk(laneOctet, eq[7:0]);
    $display("test data done");
  endtask

  task automatic mf_delay(output int d);
    @(posedge clk);
    sysrefIn <= 1'b1;
    #1;
    d = 0;
    while (multiframeStart !== 1'b1 && d < 40) begin
      cyc(1);
      d++;
    end
    @(posedge clk);
    sysrefIn <= 1'b0;
  endtask

  // Reference pulses at two phases must land the counter identically
  task automatic t_sysref;
    int d0, d1, d2;
    mf_delay(d0);
    cyc(12);
    mf_delay(d1);
    cyc(17);
    mf_delay(d2);
    chk(16'(d1), 16'(d2));
    chk(16'(d1 < 12), 16'h0001);
    cyc(31);
    chk(multiframeStart, 16'h0001);
    $display("test sysref done");
  endtask

  task automatic t_lanes;
    logic [15:0] masks [8] = '{16'hFFFF, 16'h00FF, 16'h000F, 16'h0003, 16'h0001, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      linkModeSetting <= 5'(m);
      gainBoost       <= 1'b0;
      cyc(5);
      chk(laneEnable, masks[m]);
      chk(encode66, 16'h0000);
    end
    $display("test lanes done");
  endtask

  // Block framing, FEC and SYNC handling in 64B/66B
  task automatic t_66;
    int n;
    @(posedge clk);
    linkModeSetting <= 5'h08;
    wantLink        <= 1'b0;
    cyc(8);
    chk(encode66, 16'h0001);
    chk(laneIsK, 16'h0000);
    chk(fecActive, 16'h0001);
    chk(linkUp, 16'h0001);
    feed(1, 16'h1357, 16'h0567);
    wait_oct(8'h13, 1'b0, 40);
    cyc(1);
    chk(laneOctet, 16'h0057);
    cyc(1);
    chk(laneOctet, 16'h0000);
    n = 0;
    while (blockStart !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(syncHeader, 16'h0001);
    cyc(1);
    chk(syncHeader, 16'h0000);
    cyc(7);
    chk(blockStart, 16'h0001);
    @(posedge clk);
    wantLink <= 1'b1;
    cyc(12);
    chk(linkUp, 16'h0001);
    chk(16'(oscCnt), 16'h0000);
    @(posedge clk);
    wantLink  <= 1'b0;
    syncIsOsc <= 1'b1;
    cyc(8);
    @(posedge clk);
    wantLink <= 1'b1;
    cyc(8);
    chk(16'(oscCnt), 16'h0001);
    $display("test 66 done");
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #1_000_000;
    badCount++;
    finish_test;
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk(laneOctet, 16'h00BC);
    chk(linkUp, 16'h0000);
    @(posedge clk);
    rst_b <= 1'b1;
    t_cgs;
    t_ilas;
    t_data(1'b0, 16'h1234, 16'h0567);
    t_data(1'b1, 16'h2468, 16'h0ACE);
    t_sysref;
    t_lanes;
    t_66;
    finish_test;
  end
endmodule
